// file: hw/i2c_slave_params.svh
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// clock rate of the block, in MHz
`define CLOCK_MHZ 40
// upper four bits of the identification memory address
`define EDID_ADDR_HI 4'hA
// low address bits that select the identification memory
`define EDID_ADDR_LO 3'h0
// upper four bits of the timing memory address
`define TIMING_CONTROLLER_MEMORY_ADDR_HI 4'hA
// seven-bit address of the vcom setting register
`define VCOM_ADDR 7'h4F
// address width of the identification memory (256 bytes)
`define EDID_AW 8
// address width of the timing memory (eight blocks of 256 bytes)
`define TIMING_CONTROLLER_MEMORY_AW 11
// width of the per-port byte pointer
`define PTR_W 11
// bit count that marks a whole byte
`define BYTE_BITS 4'h8
// last data bit before a byte is whole
`define LAST_BIT 4'h7
// vcom setting after reset, the stored copy and the live copy alike
`define VCOM_RESET 7'h40

`endif

// file: hw/i2c_slave_pkg.sv
`default_nettype none

package i2c_slave_pkg;

   // bit-level state of one serial port
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_RACK = 3'b100
   } link_state_e;

endpackage

`default_nettype wire

// file: hw/byte_memory.sv
`default_nettype none

// byte-wide memory, one port, read data registered
module byte_memory
#(
   parameter int AW = 8
)
(
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   // storage array
   logic [7:0] mem_reg [2**AW];

   // write on strobe, read every cycle into a register
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_reg[addr] <= wdata;
      end
      rdata <= mem_reg[addr];
   end

endmodule

`default_nettype wire

// file: hw/dual_port_i2c_memory_slave.sv
`include "i2c_slave_params.svh"
`default_nettype none

// Functional notes
// - slave only, primary and secondary two-wire ports
// - data falls with clock high: start
// - data rises with clock high: stop
// - data changes only while clock low
// - one bit per clock pulse, unlimited bytes
// - first byte: seven-bit address plus direction
// - primary memory answers low bits 000
// - secondary low bits pick one of eight blocks
// - vcom register answers address 1001111x
// - acknowledge address only on match, not busy
// - bytes are eight bits, msb first
// - read continues from last used address
// - acknowledge by holding data low, ninth pulse
// - master acknowledges reads, nacks last, stops
// - on master nack, release data line
// - primary memory and vcom share one port
// - both ports may read at once
// - other overlaps: one port nacks until done
// - program bit 1: live copy only
// - vcom writes only with write protect high
// - reads wrap from last byte to first
module dual_port_i2c_memory_slave
   import i2c_slave_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PRIMARY_SERIAL_CLOCK,
   input wire logic PRIMARY_SERIAL_DATA_IN,
   output logic PRIMARY_SERIAL_DATA_OUT,
   output logic PRIMARY_SERIAL_DATA_OE,
   input wire logic SECONDARY_SERIAL_CLOCK,
   input wire logic SECONDARY_SERIAL_DATA_IN,
   output logic SECONDARY_SERIAL_DATA_OUT,
   output logic SECONDARY_SERIAL_DATA_OE,
   input wire logic WRITE_PROTECT_INPUT,
   output logic [6:0] VCOM_SETTING_LIVE,
   output logic [6:0] VCOM_SETTING_STORED
);

   // pin bundles, index 0 primary, index 1 secondary
   logic [1:0] scl_pin;
   logic [1:0] sda_pin;
   // per-port results shared with the arbiter, the vcom logic and the pins
   logic [1:0] busy_w;
   logic [1:0] kind_wr_w;
   logic [1:0] req_w;
   logic [1:0] req_wr_w;
   logic [1:0] oe_w;
   logic [1:0] wbyte_w;
   logic [1:0] vsel_w;
   logic [7:0] wdata_w [2];
   // arbiter answers
   logic grant0;
   logic grant1;
   // write protect synchroniser
   logic wp_s1_reg;
   logic wp_s2_reg;
   // vcom copies
   logic [6:0] vcom_live_reg;
   logic [6:0] vcom_stored_reg;
   // vcom update strobes
   logic vcom_we;
   logic vcom_keep;

   assign scl_pin = {SECONDARY_SERIAL_CLOCK, PRIMARY_SERIAL_CLOCK};
   assign sda_pin = {SECONDARY_SERIAL_DATA_IN, PRIMARY_SERIAL_DATA_IN};

   // open drain: only ever pull low, enable says when
   assign PRIMARY_SERIAL_DATA_OUT = 1'b0;
   assign SECONDARY_SERIAL_DATA_OUT = 1'b0;
   assign PRIMARY_SERIAL_DATA_OE = oe_w[0];
   assign SECONDARY_SERIAL_DATA_OE = oe_w[1];

   // primary wins a conflict, but only against a port already idle;
   // two reads never conflict, any write does
   assign grant0 = req_w[0] & ~(busy_w[1] & (kind_wr_w[1] | req_wr_w[0]));
   assign grant1 = req_w[1] & ~(busy_w[0] & (kind_wr_w[0] | req_wr_w[1]))
      & ~(grant0 & (req_wr_w[0] | req_wr_w[1]));

   // write protect pin, two stages
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         wp_s1_reg <= 1'b0;
         wp_s2_reg <= 1'b0;
      end
      else
      begin
         wp_s1_reg <= WRITE_PROTECT_INPUT;
         wp_s2_reg <= wp_s1_reg;
      end
   end

   // vcom byte: upper seven bits setting, lsb program bit
   assign vcom_we = wbyte_w[0] & vsel_w[0] & wp_s2_reg;
   assign vcom_keep = wdata_w[0][0];

   // live copy always, stored copy only with program bit clear
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         vcom_live_reg <= `VCOM_RESET;
         vcom_stored_reg <= `VCOM_RESET;
      end
      else if (vcom_we)
      begin
         vcom_live_reg <= wdata_w[0][7:1];
         if (!vcom_keep)
         begin
            vcom_stored_reg <= wdata_w[0][7:1];
         end
      end
   end

   assign VCOM_SETTING_LIVE = vcom_live_reg;
   assign VCOM_SETTING_STORED = vcom_stored_reg;

   // one serial engine per port
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      // memory size of this port
      localparam int AW = (p == 0) ? `EDID_AW : `TIMING_CONTROLLER_MEMORY_AW;

      // pin synchronisers and one delayed copy for edges
      logic scl_s1_reg;
      logic scl_s2_reg;
      logic scl_d_reg;
      logic sda_s1_reg;
      logic sda_s2_reg;
      logic sda_d_reg;
      // engine state
      link_state_e st_reg;
      logic [3:0] cnt_reg;
      logic [7:0] sh_reg;
      logic first_reg;
      logic rd_reg;
      logic vsel_reg;
      logic wpend_reg;
      logic busy_reg;
      logic ack_reg;
      logic oe_reg;
      logic [`PTR_W-1:0] ptr_reg;
      // bus events
      logic scl_rise;
      logic scl_fall;
      logic start_ev;
      logic stop_ev;
      // byte handling
      logic byte_done;
      logic [7:0] rx_byte;
      logic [6:0] rx_addr;
      logic hit_mem;
      logic hit_vcom;
      logic grant;
      logic addr_win;
      logic word_load;
      logic wbyte;
      logic rd_step;
      logic ptr_inc;
      logic [`PTR_W-1:0] ptr_step;
      logic [7:0] mem_rdata;
      logic [7:0] tx_byte;
      logic cnt_clr;
      logic cnt_inc;
      logic load_tx;

      // two stages per pin, then a third for edge finding
      always_ff @(posedge CLOCK)
      begin
         if (RST)
         begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
         end
         else
         begin
            scl_s1_reg <= scl_pin[p];
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= sda_pin[p];
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
         end
      end

      // clock edges and start/stop with clock held high
      assign scl_rise = scl_s2_reg & ~scl_d_reg;
      assign scl_fall = ~scl_s2_reg & scl_d_reg;
      assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
      assign stop_ev = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

      // byte is whole on the eighth rising clock, msb first
      assign byte_done = (st_reg == ST_RX) & scl_rise & (cnt_reg == `LAST_BIT);
      assign rx_byte = {sh_reg[6:0], sda_s2_reg};
      assign rx_addr = rx_byte[7:1];

      // address decode per port
      assign hit_mem = (p == 0) ? (rx_addr == {`EDID_ADDR_HI, `EDID_ADDR_LO})
         : (rx_addr[6:3] == `TIMING_CONTROLLER_MEMORY_ADDR_HI);
      assign hit_vcom = (p == 0) && (rx_addr == `VCOM_ADDR);

      // request toward the arbiter
      assign req_w[p] = byte_done & first_reg & (hit_mem | hit_vcom);
      assign req_wr_w[p] = ~rx_byte[0];
      assign grant = (p == 0) ? grant0 : grant1;
      assign addr_win = byte_done & first_reg & grant;
      assign busy_w[p] = busy_reg;
      assign kind_wr_w[p] = ~rd_reg;
      assign oe_w[p] = oe_reg;

      // first data byte of a memory write is the word address
      assign word_load = byte_done & ~first_reg & busy_reg & ~rd_reg & wpend_reg;
      assign wbyte = byte_done & ~first_reg & busy_reg & ~rd_reg & ~wpend_reg;
      assign wbyte_w[p] = wbyte;
      assign wdata_w[p] = rx_byte;
      assign vsel_w[p] = vsel_reg;

      // a read byte is finished when the master answers it
      assign rd_step = (st_reg == ST_RACK) & scl_rise;
      assign ptr_inc = (wbyte | rd_step) & ~vsel_reg;

      // pointer wraps inside its own memory
      assign ptr_step = (p == 0) ? {3'h0, ptr_reg[7:0] + 8'h01}
         : ptr_reg + 11'h001;

      // byte offered to the master
      assign tx_byte = vsel_reg ? {vcom_stored_reg, 1'b0} : mem_rdata;

      // bit counter control
      assign cnt_clr = start_ev | (scl_fall & ((st_reg == ST_ACK) | (st_reg == ST_RACK)));
      assign cnt_inc = scl_rise & ((st_reg == ST_RX) | (st_reg == ST_TX)) & (cnt_reg != `BYTE_BITS);
      assign load_tx = scl_fall & (((st_reg == ST_ACK) & rd_reg) | ((st_reg == ST_RACK) & ack_reg));

      // this port's own memory
      byte_memory #(.AW(AW)) u_mem
      (
         .clk(CLOCK),
         .we(wbyte & ~vsel_reg),
         .addr(ptr_reg[AW-1:0]),
         .wdata(rx_byte),
         .rdata(mem_rdata)
      );

      // bit-level sequencing; start and stop override everything
      always_ff @(posedge CLOCK)
      begin
         if (RST)
         begin
            st_reg <= ST_IDLE;
         end
         else if (stop_ev)
         begin
            st_reg <= ST_IDLE;
         end
         else if (start_ev)
         begin
            st_reg <= ST_RX;
         end
         else
         begin
            unique case (st_reg)
               ST_IDLE:
               begin
                  st_reg <= ST_IDLE;
               end
               ST_RX:
               begin
                  // nack sends the port back to watching for start
                  if (scl_fall && cnt_reg == `BYTE_BITS)
                  begin
                     st_reg <= ack_reg ? ST_ACK : ST_IDLE;
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     st_reg <= rd_reg ? ST_TX : ST_RX;
                  end
               end
               ST_TX:
               begin
                  if (scl_fall && cnt_reg == `BYTE_BITS)
                  begin
                     st_reg <= ST_RACK;
                  end
               end
               ST_RACK:
               begin
                  // master nack ends the read
                  if (scl_fall)
                  begin
                     st_reg <= ack_reg ? ST_TX : ST_IDLE;
                  end
               end
               default:
               begin
                  st_reg <= ST_IDLE;
               end
            endcase
         end
      end

      // bit counter, stops at eight until the ninth pulse ends
      always_ff @(posedge CLOCK)
      begin
         if (RST || cnt_clr)
         begin
            cnt_reg <= 4'h0;
         end
         else if (cnt_inc)
         begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end

      // shared shifter: in on rising clock, out on falling
      always_ff @(posedge CLOCK)
      begin
         if (RST)
         begin
            sh_reg <= 8'h00;
         end
         else if (st_reg == ST_RX && scl_rise)
         begin
            sh_reg <= rx_byte;
         end
         else if (load_tx)
         begin
            sh_reg <= tx_byte;
         end
         else if (st_reg == ST_TX && scl_fall && cnt_reg != `BYTE_BITS)
         begin
            sh_reg <= {sh_reg[6:0], 1'b0};
         end
      end

      // data line drive, changed on a falling clock; start, stop and reset release it
      always_ff @(posedge CLOCK)
      begin
         if (RST || stop_ev || start_ev)
         begin
            oe_reg <= 1'b0;
         end
         else if (scl_fall)
         begin
            // ack low through the ninth pulse
            if (st_reg == ST_RX && cnt_reg == `BYTE_BITS)
            begin
               oe_reg <= ack_reg;
            end
            else if (load_tx)
            begin
               oe_reg <= ~tx_byte[7];
            end
            else if (st_reg == ST_TX && cnt_reg != `BYTE_BITS)
            begin
               oe_reg <= ~sh_reg[6];
            end
            else
            begin
               oe_reg <= 1'b0;
            end
         end
      end

      // acknowledge decision for received and sent bytes
      always_ff @(posedge CLOCK)
      begin
         if (RST)
         begin
            ack_reg <= 1'b0;
         end
         else if (byte_done)
         begin
            ack_reg <= first_reg ? grant : (busy_reg & ~rd_reg);
         end
         else if (rd_step)
         begin
            ack_reg <= ~sda_s2_reg;
         end
      end

      // session flags, held from address acknowledge to stop
      always_ff @(posedge CLOCK)
      begin
         if (RST || stop_ev)
         begin
            busy_reg <= 1'b0;
            rd_reg <= 1'b0;
            vsel_reg <= 1'b0;
            wpend_reg <= 1'b0;
         end
         else if (byte_done && first_reg)
         begin
            busy_reg <= grant;
            rd_reg <= rx_byte[0];
            vsel_reg <= hit_vcom;
            wpend_reg <= ~rx_byte[0] & ~hit_vcom;
         end
         else if (word_load)
         begin
            wpend_reg <= 1'b0;
         end
      end

      // next received byte is an address byte after each start
      always_ff @(posedge CLOCK)
      begin
         if (RST || start_ev)
         begin
            first_reg <= 1'b1;
         end
         else if (byte_done)
         begin
            first_reg <= 1'b0;
         end
      end

      // byte pointer survives between transfers
      always_ff @(posedge CLOCK)
      begin
         if (RST)
         begin
            ptr_reg <= '0;
         end
         else if (addr_win && p == 1)
         begin
            ptr_reg <= {rx_byte[3:1], ptr_reg[7:0]};
         end
         else if (word_load)
         begin
            ptr_reg <= (p == 0) ? {3'h0, rx_byte} : {ptr_reg[10:8], rx_byte};
         end
         else if (ptr_inc)
         begin
            ptr_reg <= ptr_step;
         end
      end
   end

endmodule

`default_nettype wire

// file: testbench/slave_asserts.sv
`default_nettype none
// pin-level watch on the dual-port slave
module slave_checker
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PRIMARY_SERIAL_CLOCK,
   input wire logic PRIMARY_SERIAL_DATA_IN,
   input wire logic PRIMARY_SERIAL_DATA_OUT,
   input wire logic PRIMARY_SERIAL_DATA_OE,
   input wire logic SECONDARY_SERIAL_CLOCK,
   input wire logic SECONDARY_SERIAL_DATA_IN,
   input wire logic SECONDARY_SERIAL_DATA_OUT,
   input wire logic SECONDARY_SERIAL_DATA_OE,
   input wire logic WRITE_PROTECT_INPUT,
   input wire logic [6:0] VCOM_SETTING_LIVE,
   input wire logic [6:0] VCOM_SETTING_STORED
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wp_hist; // last four samples of write protect
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // history of the protect pin
   always_ff @(posedge CLOCK)
      wp_hist <= {wp_hist[2:0], WRITE_PROTECT_INPUT};
   chk_drive_low: assert property (!PRIMARY_SERIAL_DATA_OUT && !SECONDARY_SERIAL_DATA_OUT)
      else $error("data drive value not low");
   chk_reset_idle: assert property (@(posedge CLOCK) disable iff (1'b0) RST |=>
      !PRIMARY_SERIAL_DATA_OE && !SECONDARY_SERIAL_DATA_OE && VCOM_SETTING_LIVE == 7'h40)
      else $error("outputs not idle under reset");
   chk_hold_pri: assert property (PRIMARY_SERIAL_CLOCK && $past(PRIMARY_SERIAL_CLOCK) |->
      $stable(PRIMARY_SERIAL_DATA_OE)) else $error("primary data moved in high phase");
   chk_hold_sec: assert property (SECONDARY_SERIAL_CLOCK && $past(SECONDARY_SERIAL_CLOCK) |->
      $stable(SECONDARY_SERIAL_DATA_OE)) else $error("secondary data moved in high phase");
   chk_start_free: assert property ($fell(PRIMARY_SERIAL_DATA_IN) && PRIMARY_SERIAL_CLOCK &&
      $past(PRIMARY_SERIAL_CLOCK) |-> ##[0:6] !PRIMARY_SERIAL_DATA_OE) else $error("start not freeing data");
   chk_stop_free: assert property ($rose(PRIMARY_SERIAL_DATA_IN) && PRIMARY_SERIAL_CLOCK &&
      $past(PRIMARY_SERIAL_CLOCK) |=> !PRIMARY_SERIAL_DATA_OE [*4]) else $error("data pulled after stop");
   chk_wp_block: assert property (wp_hist == 4'h0 && !WRITE_PROTECT_INPUT |->
      $stable(VCOM_SETTING_LIVE) && $stable(VCOM_SETTING_STORED)) else $error("setting moved while protected");
   chk_both_copy: assert property (!$stable(VCOM_SETTING_STORED) |->
      VCOM_SETTING_LIVE == VCOM_SETTING_STORED) else $error("stored copy updated alone");
endmodule
bind dual_port_i2c_memory_slave slave_checker chk
(
   .CLOCK(CLOCK), .RST(RST), .WRITE_PROTECT_INPUT(WRITE_PROTECT_INPUT),
   .PRIMARY_SERIAL_CLOCK(PRIMARY_SERIAL_CLOCK), .PRIMARY_SERIAL_DATA_IN(PRIMARY_SERIAL_DATA_IN),
   .PRIMARY_SERIAL_DATA_OUT(PRIMARY_SERIAL_DATA_OUT), .PRIMARY_SERIAL_DATA_OE(PRIMARY_SERIAL_DATA_OE),
   .SECONDARY_SERIAL_CLOCK(SECONDARY_SERIAL_CLOCK), .SECONDARY_SERIAL_DATA_IN(SECONDARY_SERIAL_DATA_IN),
   .SECONDARY_SERIAL_DATA_OUT(SECONDARY_SERIAL_DATA_OUT), .SECONDARY_SERIAL_DATA_OE(SECONDARY_SERIAL_DATA_OE),
   .VCOM_SETTING_LIVE(VCOM_SETTING_LIVE), .VCOM_SETTING_STORED(VCOM_SETTING_STORED)
);
`default_nettype wire

// file: testbench/link_master.sv
`default_nettype none
// bus master for one port; data line has a pull-up
module link_master
(
   input wire logic clk,
   input wire logic dev_oe,
   output logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic m_oe; // master pulls data low
   assign sda = ~(m_oe | dev_oe); // low while either side pulls
   // idle bus from time zero
   initial
   begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   // one bit: data moves in low phase, sampled at end of high
   task automatic bit_x(input logic b, output logic r);
      @(posedge clk);
      m_oe <= ~b;
      repeat (3) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      r = sda;
      scl <= 1'b0;
   endtask
   // start (s high) or stop (s low): data moves while clock high
   task automatic cond(input logic s);
      @(posedge clk);
      m_oe <= ~s;
      repeat (3) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      m_oe <= s;
      repeat (4) @(posedge clk);
      scl <= ~s;
   endtask
   // byte msb first plus ninth bit; lst high releases the ninth
   task automatic byte_x(input logic [7:0] d, input logic lst, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]);
      bit_x(lst, r);
      ack = ~r;
   endtask
   // start, bytes out until refused, k bytes in, stop
   task automatic xfer(input logic [7:0] o[$], input int k, output logic [7:0] n,
      output logic [7:0] r[$], output logic rel);
      logic a;
      logic [7:0] d;
      n = 8'h00;
      r = {};
      cond(1'b1);
      foreach (o[i])
      begin
         byte_x(o[i], 1'b1, d, a);
         if (a !== 1'b1)
            break;
         n++;
      end
      for (int i = 0; i < k && n == o.size(); i++)
      begin
         byte_x(8'hFF, i == k - 1, d, a);
         r.push_back(d);
      end
      repeat (6) @(posedge clk);
      rel = ~dev_oe;
      cond(1'b0);
   endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
// two masters around the dual-port slave
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst, wp; // clock, reset, write protect
   logic p_scl, s_scl; // serial clocks from the masters
   wire logic p_sda, s_sda; // resolved data lines
   logic p_oe, s_oe; // slave data pulls
   logic [6:0] live, stored; // calibration copies
   int err_total, num_checks, cycles;
   dual_port_i2c_memory_slave DUT
   (
      .CLOCK(clock), .RST(rst), .WRITE_PROTECT_INPUT(wp),
      .PRIMARY_SERIAL_CLOCK(p_scl), .PRIMARY_SERIAL_DATA_IN(p_sda),
      .PRIMARY_SERIAL_DATA_OUT(), .PRIMARY_SERIAL_DATA_OE(p_oe),
      .SECONDARY_SERIAL_CLOCK(s_scl), .SECONDARY_SERIAL_DATA_IN(s_sda),
      .SECONDARY_SERIAL_DATA_OUT(), .SECONDARY_SERIAL_DATA_OE(s_oe),
      .VCOM_SETTING_LIVE(live), .VCOM_SETTING_STORED(stored)
   );
   link_master pm(.clk(clock), .dev_oe(p_oe), .scl(p_scl), .sda(p_sda));
   link_master sm(.clk(clock), .dev_oe(s_oe), .scl(s_scl), .sda(s_sda));
   // 40 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // compare, count, report
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // counts and verdict
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_total++;
         final_report();
      end
   end
   // primary memory: write, set pointer, reads carry on and wrap
   task automatic t_mem();
      logic [7:0] n;
      logic [7:0] r[$];
      logic rel;
      pm.xfer('{8'hA0, 8'h05, 8'hD3, 8'h5A}, 0, n, r, rel);
      check("write acks", n, 8'h04);
      pm.xfer('{8'hA0, 8'h05}, 0, n, r, rel);
      pm.xfer('{8'hA1}, 1, n, r, rel);
      check("read at set address", r[0], 8'hD3);
      check("data released on nack", {7'h00, rel}, 8'h01);
      pm.xfer('{8'hA1}, 1, n, r, rel);
      check("read carries on", r[0], 8'h5A);
      pm.xfer('{8'hA0, 8'hFF, 8'h11, 8'h22}, 0, n, r, rel);
      pm.xfer('{8'hA0, 8'hFF}, 0, n, r, rel);
      pm.xfer('{8'hA1}, 2, n, r, rel);
      check("last byte", r[0], 8'h11);
      check("read wraps", r[1], 8'h22);
      pm.xfer('{8'hA2, 8'h00}, 0, n, r, rel);
      check("other block refused", n, 8'h00);
      pm.xfer('{8'h90, 8'h00}, 0, n, r, rel);
      check("foreign address refused", n, 8'h00);
   endtask
   // each timing memory block keeps its own byte
   task automatic t_blocks();
      logic [7:0] n;
      logic [7:0] r[$];
      logic rel;
      for (int b = 0; b < 8; b++)
         sm.xfer('{{4'hA, 3'(b), 1'b0}, 8'h30, 8'hB0 | 8'(b)}, 0, n, r, rel);
      for (int b = 0; b < 8; b++)
      begin
         sm.xfer('{{4'hA, 3'(b), 1'b0}, 8'h30}, 0, n, r, rel);
         sm.xfer('{{4'hA, 3'(b), 1'b1}}, 1, n, r, rel);
         check("block byte", r[0], 8'hB0 | 8'(b));
      end
   endtask
   // calibration register: protect, program bit, stored readback
   task automatic t_vcom();
      logic [7:0] n;
      logic [7:0] r[$];
      logic rel;
      pm.xfer('{8'h9E, 8'h2B}, 0, n, r, rel);
      check("protected write acked", n, 8'h02);
      check("protected live", {1'b0, live}, 8'h40);
      @(posedge clock);
      wp <= 1'b1;
      pm.xfer('{8'h9E, 8'h2B}, 0, n, r, rel);
      check("live only", {1'b0, live}, 8'h15);
      check("stored kept", {1'b0, stored}, 8'h40);
      pm.xfer('{8'h9F}, 1, n, r, rel);
      check("read stored copy", r[0], 8'h80);
      pm.xfer('{8'h9E, 8'h54}, 0, n, r, rel);
      check("live both", {1'b0, live}, 8'h2A);
      check("stored both", {1'b0, stored}, 8'h2A);
      @(posedge clock);
      wp <= 1'b0;
   endtask
   // concurrent reads, then a write refused while the other port is busy
   task automatic t_ports();
      logic [7:0] n;
      logic [7:0] d;
      logic [7:0] r[$];
      logic [7:0] q[$];
      logic rel, a;
      pm.xfer('{8'hA0, 8'h05}, 0, n, r, rel);
      sm.xfer('{8'hA6, 8'h30}, 0, n, q, rel);
      fork
         pm.xfer('{8'hA1}, 2, n, r, rel);
         sm.xfer('{8'hA7}, 1, d, q, a);
      join
      check("primary shared read", r[1], 8'h5A);
      check("secondary shared read", q[0], 8'hB3);
      pm.cond(1'b1);
      pm.byte_x(8'hA0, 1'b1, d, a);
      check("first address taken", {7'h00, a}, 8'h01);
      sm.xfer('{8'hA0, 8'h30}, 0, n, q, rel);
      check("write refused while busy", n, 8'h00);
      pm.byte_x(8'h05, 1'b1, d, a);
      pm.cond(1'b0);
      sm.xfer('{8'hA0, 8'h30}, 0, n, q, rel);
      check("write taken after stop", n, 8'h02);
   endtask
   // reset, scenarios, verdict
   initial
   begin
      rst = 1'b1;
      wp = 1'b0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("live after reset", {1'b0, live}, 8'h40);
      check("stored after reset", {1'b0, stored}, 8'h40);
      t_mem();
      t_blocks();
      t_vcom();
      t_ports();
      final_report();
   end
endmodule
`default_nettype wire
